// ==== rtl/status_register_write_protect.sv ====
// Function
// - Serial bits travel most significant first
// - Opcode 05h reads status, no address
// - Opcode 01h writes exactly one byte
// - Write frames must end on byte boundary
// - Status read answered even while busy
// - Status bytes repeat while select stays low
// - Busy flag set during any write cycle
// - Latch flag mirrors latch; clear refuses writes
// - Guard bits non-volatile, block page/sector writes
// - Full wipe only when all guards zero
// - Lock bit plus low pin locks status
// - Status write needs latch set beforehand
// - Status write keeps b6, b5, b1, b0
// - Bits b6 and b5 read zero
// - Select must rise right after data byte
// - Select rise starts timed write, busy shown
// - Latch cleared when write cycle completes
// - Lock bit clear: pin level ignored
// - Lock bit set, pin high: writes allowed
// - Lock mode entered whichever event comes last
// - Pin high or lock bit cleared by write cycle releases lock mode
`timescale 1ns/1ps
`include "status_protect_consts.svh"

module status_register_write_protect
  import status_protect_pkg::*;
#(
  parameter int WRITE_TIME_NS = `WRITE_TIME_NS_DFLT
) (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  output logic            so,
  output logic            so_oe,
  input  wire logic       write_protect_pin_n,
  input  wire logic       ext_busy,
  input  wire logic       ext_cycle_done,
  output logic            write_latch_flag,
  output logic            cycle_active_flag,
  output logic [2:0]      block_guard_bits,
  output logic            hardware_lock_mode,
  output logic            full_wipe_ok,
  output status_byte_t    status_byte
);

  // ============================================================
  // Timing
  localparam int WRITE_CYCLES_I = (WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int WRITE_CYCLES   = (WRITE_CYCLES_I < 1) ? 1 : WRITE_CYCLES_I;
  localparam logic [23:0] WRITE_LAST = 24'(WRITE_CYCLES - 1);

  // ============================================================
  // Serial clock domain: frame capture
  logic        frame_clr;
  logic        active_r;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_r;
  logic        frame_tgl_r;

  // Frame end clears the active flag and read output; the serial logic sees no clock outside a frame
  assign frame_clr = cs_n | ~nrst;

  always_ff @(posedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      active_r <= 1'b0;
    end else begin
      active_r <= 1'b1;
    end
  end

  // Count and shift value are left standing after select rises for the
  // main clock to sample; only a new frame overwrites them.
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_r   <= 5'h00;
      shift_r     <= 16'h0000;
      frame_tgl_r <= 1'b0;
    end else if (!active_r) begin
      bit_cnt_r   <= 5'h01;
      shift_r     <= {15'h0000, si};
      frame_tgl_r <= ~frame_tgl_r;
    end else begin
      if (bit_cnt_r != `FRAME_CNT_MAX) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      shift_r <= {shift_r[14:0], si};
    end
  end

  // ============================================================
  // Serial clock domain: status byte crossing
  status_byte_t stat_r;
  status_byte_t stat_s;
  status_byte_t stat_s_d;
  status_byte_t stat_hold_r;

  bit_sync2 #(
    .WIDTH   (8),
    .RST_VAL (`STATUS_RESET)
  ) u_stat_sync (
    .clk  (sclk),
    .nrst (nrst),
    .d    (stat_r),
    .q    (stat_s)
  );

  // Only a value seen twice in a row is taken, so a byte caught
  // mid-change is never shifted out.
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      stat_s_d    <= `STATUS_RESET;
      stat_hold_r <= `STATUS_RESET;
    end else begin
      stat_s_d <= stat_s;
      if (stat_s == stat_s_d) begin
        stat_hold_r <= stat_s_d;
      end
    end
  end

  // ============================================================
  // Serial clock domain: status read output
  logic         rd_on_r;
  logic [2:0]   rd_bit_r;
  status_byte_t rd_byte_r;
  logic         rd_start;

  assign rd_start = (bit_cnt_r == `FRAME_OPCODE_ONLY)
                 && (shift_r[7:0] == `OP_STATUS_READ);

  always_ff @(negedge sclk or posedge frame_clr) begin
    if (frame_clr) begin
      rd_on_r   <= 1'b0;
      rd_bit_r  <= 3'h0;
      rd_byte_r <= `STATUS_RESET;
      so        <= 1'b0;
      so_oe     <= 1'b0;
    end else if (!rd_on_r) begin
      if (rd_start) begin
        rd_on_r   <= 1'b1;
        so_oe     <= 1'b1;
        rd_byte_r <= stat_hold_r;
        so        <= stat_hold_r[7];
        rd_bit_r  <= 3'h1;
      end
    end else begin
      rd_bit_r <= rd_bit_r + 3'h1;
      if (rd_bit_r == 3'h0) begin
        rd_byte_r <= stat_hold_r;
        so        <= stat_hold_r[7];
      end else begin
        so <= rd_byte_r[3'h7 - rd_bit_r];
      end
    end
  end

  // ============================================================
  // Main clock domain: pin and frame synchronisers
  logic cs_s;
  logic cs_d;
  logic wp_s;
  logic cs_rise;
  logic tgl_s;
  logic tgl_seen_r;
  logic frame_new;

  bit_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_cs_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (cs_n),
    .q    (cs_s)
  );

  bit_sync2 #(
    .WIDTH   (1),
    .RST_VAL (1'b1)
  ) u_wp_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (write_protect_pin_n),
    .q    (wp_s)
  );

  bit_sync2 u_tgl_sync (
    .clk  (mclk),
    .nrst (nrst),
    .d    (frame_tgl_r),
    .q    (tgl_s)
  );

  // Toggle marks a frame that carried clocks; an empty select pulse
  // must not replay the command still standing in the frame registers.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cs_d       <= 1'b1;
      tgl_seen_r <= 1'b0;
    end else begin
      cs_d <= cs_s;
      if (cs_rise) begin
        tgl_seen_r <= tgl_s;
      end
    end
  end

  assign cs_rise   = cs_s & ~cs_d;
  assign frame_new = tgl_s ^ tgl_seen_r;

  // ============================================================
  // Main clock domain: command decode at frame end
  // Frame registers are static here: the serial clock is idle while
  // select is high. A new frame must not start within a few main clocks.
  logic wr_frame_ok;
  logic op_frame_ok;
  logic lock_now;
  logic busy_now;
  logic latch_set_go;
  logic latch_clr_go;
  logic status_wr_go;
  logic wr_done;

  logic            latch_r;
  logic [2:0]      guard_r;
  logic            lock_r;
  logic [7:0]      pend_r;
  wr_state_e       wr_state_r;
  logic [23:0]     wr_cnt_r;

  assign op_frame_ok  = frame_new & (bit_cnt_r == `FRAME_OPCODE_ONLY);
  assign wr_frame_ok  = frame_new & (bit_cnt_r == `FRAME_OPCODE_DATA);
  assign lock_now     = lock_r & ~wp_s;
  assign busy_now     = (wr_state_r == WR_RUN) | ext_busy;
  assign latch_set_go = cs_rise & op_frame_ok & ~busy_now
                      & (shift_r[7:0] == `OP_LATCH_SET);
  assign latch_clr_go = cs_rise & op_frame_ok & ~busy_now
                      & (shift_r[7:0] == `OP_LATCH_CLEAR);
  // Lock bit clear or pin high leaves only the latch and the busy state as the gates
  assign status_wr_go = cs_rise & wr_frame_ok & ~busy_now
                      & (shift_r[15:8] == `OP_STATUS_WRITE)
                      & latch_r & ~lock_now;
  assign wr_done      = (wr_state_r == WR_RUN) && (wr_cnt_r == 24'h000000);

  // ============================================================
  // Main clock domain: write cycle timer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_state_r <= WR_IDLE;
      wr_cnt_r   <= 24'h000000;
      pend_r     <= 8'h00;
    end else begin
      unique case (wr_state_r)
        WR_IDLE: begin
          if (status_wr_go) begin
            wr_state_r <= WR_RUN;
            wr_cnt_r   <= WRITE_LAST;
            pend_r     <= shift_r[7:0];
          end
        end
        WR_RUN: begin
          if (wr_cnt_r == 24'h000000) begin
            wr_state_r <= WR_IDLE;
          end else begin
            wr_cnt_r <= wr_cnt_r - 24'h000001;
          end
        end
      endcase
    end
  end

  // ============================================================
  // Main clock domain: status bits
  // Set wins over any clear arriving in the same cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      latch_r <= 1'b0;
    end else if (latch_set_go) begin
      latch_r <= 1'b1;
    end else if (latch_clr_go || wr_done || ext_cycle_done) begin
      latch_r <= 1'b0;
    end
  end

  // Non-volatile bits: reset models the delivery state only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      guard_r <= `GUARD_RESET;
      lock_r  <= `LOCK_RESET;
    end else if (wr_done) begin
      guard_r <= pend_r[`ST_GUARD_MSB:`ST_GUARD_LSB];
      lock_r  <= pend_r[`ST_LOCK_BIT];
    end
  end

  // ============================================================
  // Main clock domain: registered outputs
  status_byte_t stat_c;

  always_comb begin
    stat_c                              = `STATUS_RESET;
    stat_c[`ST_BUSY_BIT]                = busy_now;
    stat_c[`ST_LATCH_BIT]               = latch_r;
    stat_c[`ST_GUARD_MSB:`ST_GUARD_LSB] = guard_r;
    stat_c[`ST_LOCK_BIT]                = lock_r;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_r             <= `STATUS_RESET;
      status_byte        <= `STATUS_RESET;
      write_latch_flag   <= 1'b0;
      cycle_active_flag  <= 1'b0;
      block_guard_bits   <= `GUARD_RESET;
      hardware_lock_mode <= 1'b0;
      full_wipe_ok       <= 1'b0;
    end else begin
      stat_r             <= stat_c;
      status_byte        <= stat_c;
      write_latch_flag   <= latch_r;
      cycle_active_flag  <= busy_now;
      block_guard_bits   <= guard_r;
      hardware_lock_mode <= lock_now;
      full_wipe_ok       <= latch_r & ~busy_now & (guard_r == 3'h0);
    end
  end

endmodule

// ==== rtl/status_protect_consts.svh ====
`ifndef STATUS_PROTECT_CONSTS_SVH
`define STATUS_PROTECT_CONSTS_SVH

// ============================================================
// Instruction codes
`define OP_STATUS_READ     8'h05
`define OP_STATUS_WRITE    8'h01
`define OP_LATCH_SET       8'h06
`define OP_LATCH_CLEAR     8'h04

// ============================================================
// Frame lengths in serial clocks
`define FRAME_OPCODE_ONLY  5'h08
`define FRAME_OPCODE_DATA  5'h10
`define FRAME_CNT_MAX      5'h1f

// ============================================================
// Status byte layout
`define ST_BUSY_BIT        0
`define ST_LATCH_BIT       1
`define ST_GUARD_LSB       2
`define ST_GUARD_MSB       4
`define ST_LOCK_BIT        7

// ============================================================
// Reset and delivery values
`define GUARD_RESET        3'h0
`define LOCK_RESET         1'b0
`define STATUS_RESET       8'h00

// ============================================================
// Timing
`define CLK_PERIOD_NS      10
`define WRITE_TIME_NS_DFLT 1000000

`endif

// ==== rtl/status_protect_pkg.sv ====
package status_protect_pkg;

  typedef enum logic {
    WR_IDLE,
    WR_RUN
  } wr_state_e;

  typedef logic [7:0] status_byte_t;

endpackage

// ==== rtl/bit_sync2.sv ====
`timescale 1ns/1ps

module bit_sync2 #(
  parameter int             WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // First stage feeds the second stage only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

// ==== tb/status_register_write_protect_properties.sv ====
`timescale 1ns/1ps
module status_register_write_protect_properties
  import status_protect_pkg::*;
(
  input wire logic         mclk,
  input wire logic         nrst,
  input wire logic         cs_n,
  input wire logic         so,
  input wire logic         so_oe,
  input wire logic         write_protect_pin_n,
  input wire logic         ext_busy,
  input wire logic         write_latch_flag,
  input wire logic         cycle_active_flag,
  input wire logic [2:0]   block_guard_bits,
  input wire logic         hardware_lock_mode,
  input wire logic         full_wipe_ok,
  input wire status_byte_t status_byte
);
  // ============================================================
  // Properties
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_zero_bits;
    status_byte[6:5] == 2'b00;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("reserved bits set");
  // Flags are registered with the byte in the same cycle; only values stable for three cycles are compared
  property p_layout;
    $stable({cycle_active_flag, write_latch_flag, block_guard_bits})[*3] |->
      status_byte[4:0] == {block_guard_bits, write_latch_flag, cycle_active_flag};
  endproperty
  a_layout: assert property (p_layout) else $error("status layout");
  property p_lock_on;
    (status_byte[7] && !write_protect_pin_n)[*5] |-> hardware_lock_mode;
  endproperty
  a_lock_on: assert property (p_lock_on) else $error("lock mode missing");
  property p_lock_off;
    write_protect_pin_n[*5] |-> !hardware_lock_mode;
  endproperty
  a_lock_off: assert property (p_lock_off) else $error("lock mode held");
  property p_guard_chg;
    $changed(block_guard_bits) |-> $past(cycle_active_flag);
  endproperty
  a_guard_chg: assert property (p_guard_chg) else $error("guard change");
  property p_wipe;
    full_wipe_ok |-> block_guard_bits == 3'h0;
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe allowed");
  property p_ext_busy;
    ext_busy |-> ##[1:2] cycle_active_flag;
  endproperty
  a_ext_busy: assert property (p_ext_busy) else $error("busy missing");
  property p_own_cycle;
    $rose(cycle_active_flag) && !$past(ext_busy) && !$past(ext_busy, 2) |->
      $past(write_latch_flag);
  endproperty
  a_own_cycle: assert property (p_own_cycle) else $error("write no latch");
  property p_latch_done;
    $fell(cycle_active_flag) && !$past(ext_busy) |-> ##[0:2] !write_latch_flag;
  endproperty
  a_latch_done: assert property (p_latch_done) else $error("latch kept");
  property p_idle_out;
    cs_n |-> !so_oe && !so;
  endproperty
  a_idle_out: assert property (p_idle_out) else $error("output driven");
endmodule
bind status_register_write_protect status_register_write_protect_properties u_props (
  .mclk(mclk), .nrst(nrst), .cs_n(cs_n), .so(so), .so_oe(so_oe),
  .write_protect_pin_n(write_protect_pin_n), .ext_busy(ext_busy),
  .write_latch_flag(write_latch_flag), .cycle_active_flag(cycle_active_flag),
  .block_guard_bits(block_guard_bits), .hardware_lock_mode(hardware_lock_mode),
  .full_wipe_ok(full_wipe_ok), .status_byte(status_byte));

// ==== tb/spi_host_model.sv ====
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si   = 1'b0;
  end
  // ============================================================
  // Whole-byte frames, clock still between them
  task automatic frame(input logic [63:0] d, input int nbytes, output logic [63:0] q);
    q = '0;
    cs_n = 1'b0;
    for (int i = 0; i < 8 * nbytes; i++) begin
      si = d[63 - i]; // Opcode then data, MSB first
      #24 sclk = 1'b1;
      q = {q[62:0], so};
      #24 sclk = 1'b0;
    end
    #24 cs_n = 1'b1;
    si = ~si; // Released line must not look stable
    #100;
  endtask
endmodule

// ==== tb/tb_status_register_write_protect.sv ====
`timescale 1ns/1ps
module tb_status_register_write_protect;
  import status_protect_pkg::*;
  logic         mclk, nrst, pin_n, ext_busy, ext_done;
  wire logic    sclk, cs_n, si, so, so_oe, wlf, caf, hlm, fwo;
  wire logic [2:0] bg;
  status_byte_t sb;
  int           failures = 0;
  int           n_tests = 0;
  logic [63:0]  q;
  status_register_write_protect #(.WRITE_TIME_NS(2000)) dut (
    .mclk(mclk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .write_protect_pin_n(pin_n), .ext_busy(ext_busy), .ext_cycle_done(ext_done),
    .write_latch_flag(wlf), .cycle_active_flag(caf), .block_guard_bits(bg),
    .hardware_lock_mode(hlm), .full_wipe_ok(fwo), .status_byte(sb));
  spi_host_model host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ============================================================
  // Tasks
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(logic [23:0] d, int n);
    @(negedge mclk);
    host.frame({d, 40'h0}, n, q);
  endtask
  task automatic rd(int n);
    @(negedge mclk);
    host.frame({8'h05, 56'h0}, n + 1, q);
  endtask
  task automatic pin(logic v);
    @(negedge mclk) pin_n = v;
    repeat (8) @(negedge mclk);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ============================================================
  // Tests
  initial begin
    nrst = 1'b0;
    pin_n = 1'b0;
    ext_busy = 1'b0;
    ext_done = 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk) nrst = 1'b1;
    repeat (3) @(negedge mclk);
    check("reset byte", sb, 8'h00);
    rd(1);
    check("reset read", q[7:0], 8'h00);
    cmd(24'h01ff00, 2);
    rd(1);
    check("no latch", q[7:0], 8'h00);
    $display("test reset done");
    cmd(24'h060000, 1);
    rd(2);
    check("latch b1", q[15:8], 8'h02);
    check("latch b2", q[7:0], 8'h02);
    cmd(24'h01ff00, 2);
    rd(6); // Poll while busy
    check("busy read", q[47:40], 8'h03);
    check("done read", q[7:0], 8'h9c);
    check("guards", {5'h0, bg}, 8'h07);
    check("lock mode", {7'h0, hlm}, 8'h01);
    $display("test status write done");
    cmd(24'h060000, 1);
    cmd(24'h010000, 2);
    // Empty select pulse with the pin high must not replay the refused write
    pin(1'b1);
    cmd(24'h000000, 0);
    pin(1'b0);
    rd(1);
    check("locked", q[7:0], 8'h9e);
    check("wipe guarded", {7'h0, fwo}, 8'h00);
    pin(1'b1);
    check("unlock", {7'h0, hlm}, 8'h00);
    cmd(24'h018000, 2);
    #2500;
    rd(1);
    check("pin high", q[7:0], 8'h80);
    pin(1'b0);
    check("relock", {7'h0, hlm}, 8'h01);
    pin(1'b1);
    cmd(24'h060000, 1);
    cmd(24'h010000, 2);
    #2500;
    pin(1'b0);
    check("lock off", {7'h0, hlm}, 8'h00);
    $display("test lock done");
    cmd(24'h060000, 1);
    cmd(24'h011c00, 3);
    rd(1);
    check("long write", q[7:0], 8'h02);
    cmd(24'h040000, 1);
    rd(1);
    check("latch clear", q[7:0], 8'h00);
    cmd(24'h060000, 2);
    rd(1);
    check("long set", q[7:0], 8'h00);
    $display("test framing done");
    cmd(24'h060000, 1);
    repeat (10) @(negedge mclk);
    check("wipe ok", {7'h0, fwo}, 8'h01);
    @(negedge mclk) ext_busy = 1'b1;
    rd(1);
    check("ext busy", q[7:0], 8'h03);
    @(negedge mclk) ext_done = 1'b1;
    @(negedge mclk) begin
      ext_done = 1'b0;
      ext_busy = 1'b0;
    end
    rd(1);
    check("ext done", q[7:0], 8'h00);
    $display("test external cycle done");
    conclude();
  end
  initial begin
    #200000;
    failures++;
    conclude();
  end
endmodule
